// >>> core/sseq_pkg.sv
// constants shared by the status event and error queue block
// Notes on behaviour
// - each of three groups (measurement, operation, questionable) has a readable condition, a readable event and a read-write enable register.
// - event bits clear at power-up and on clear-status, not on status preset.
// - enable bits clear at power-up and on status preset, not on clear-status.
// - an enable value is taken as decimal, hexadecimal, octal or binary digits.
// - the error queue empties at power-up and on clear-status.
// - reset, system preset and status preset remove no queue entry.
// - the enabled and disabled message lists reset only at power-up.
// - the reset command and system preset change nothing in this block.
// - a next-error read returns and removes the oldest entry, code and message.
// - an all-errors read returns every entry, code and message, and empties the queue.
// - a count request reports the queue fill and removes nothing.
// - code-only reads remove entries like full reads but return no message.
// - codes in the disable list are not queued, and both lists read back.
// - a queue-clear removes every pending entry at once.
// - a register answer carries the selected status data format.
package sseq_pkg;
	localparam int REG_W = 16;
	localparam int GRP_N = 3;
	localparam int CODE_W = 16;
	localparam int MSG_W = 8;
	localparam int Q_DEPTH = 10;
	localparam int LIST_N = 8;
	// group indices
	localparam logic [1:0] GRP_MEAS = 2'h0;
	localparam logic [1:0] GRP_OPER = 2'h1;
	localparam logic [1:0] GRP_QUES = 2'h2;
	// register select within a group
	localparam logic [1:0] SEL_COND = 2'h0;
	localparam logic [1:0] SEL_EVENT = 2'h1;
	localparam logic [1:0] SEL_ENABLE = 2'h2;
	// number forms and answer formats
	localparam logic [1:0] RADIX_DEC = 2'h0;
	localparam logic [1:0] RADIX_HEX = 2'h1;
	localparam logic [1:0] RADIX_OCT = 2'h2;
	localparam logic [1:0] RADIX_BIN = 2'h3;
	// list select
	localparam logic LIST_ENABLE = 1'b0;
	localparam logic LIST_DISABLE = 1'b1;
	// reset values
	localparam logic [REG_W-1:0] EVENT_RST = 16'h0000;
	localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
	localparam logic [CODE_W-1:0] NO_ERR_CODE = 16'h0000;
	localparam logic [MSG_W-1:0] NO_ERR_MSG = 8'h00;
endpackage

// >>> core/sseq_q_if.sv
// link between the status block and its error queue
`timescale 1ns/100ps
interface sseq_q_if #(
	parameter int DEPTH  = sseq_pkg::Q_DEPTH,
	parameter int CODE_W = sseq_pkg::CODE_W,
	parameter int MSG_W  = sseq_pkg::MSG_W
);
	localparam int CNT_W = $clog2(DEPTH + 1);
	logic              push;
	logic [CODE_W-1:0] push_code;
	logic [MSG_W-1:0]  push_msg;
	logic              pop;
	logic              clr;
	logic [CNT_W-1:0]  count;
	logic [CODE_W-1:0] head_code;
	logic [MSG_W-1:0]  head_msg;

	modport owner (output push, push_code, push_msg, pop, clr, input count, head_code, head_msg);
	modport queue (input push, push_code, push_msg, pop, clr, output count, head_code, head_msg);
endinterface

// >>> core/sseq_errq.sv
// error queue storage: oldest entry at the head, clear and push may share a cycle
`timescale 1ns/100ps
module sseq_errq #(
	parameter int DEPTH  = sseq_pkg::Q_DEPTH,
	parameter int CODE_W = sseq_pkg::CODE_W,
	parameter int MSG_W  = sseq_pkg::MSG_W
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// queue side of the link
	sseq_q_if.queue   q
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	logic [CODE_W+MSG_W-1:0] mem [DEPTH];
	logic [PW-1:0]           rp;
	logic [PW-1:0]           wp;
	logic [CNT_W-1:0]        cnt;

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// a full queue drops the new entry unless a pop or a clear frees a slot in the same cycle
	wire           do_pop  = q.pop & (cnt != '0) & ~q.clr;
	wire           do_push = q.push & (q.clr | (cnt != FULL_CNT) | do_pop);
	wire [PW-1:0]  wr_idx  = q.clr ? '0 : wp;

	assign q.count     = cnt;
	assign q.head_code = mem[rp][CODE_W+MSG_W-1:MSG_W];
	assign q.head_msg  = mem[rp][MSG_W-1:0];

	// storage write
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_idx] <= {q.push_code, q.push_msg};
		end
	end

	// pointers: a clear empties at once, an entry arriving with it is kept
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rp  <= '0;
			wp  <= '0;
			cnt <= '0;
		end else if (q.clr) begin
			rp  <= '0;
			wp  <= do_push ? PW'(1) : '0;
			cnt <= do_push ? CNT_W'(1) : '0;
		end else begin
			if (do_pop) rp <= step(rp);
			if (do_push) wp <= step(wp);
			cnt <= cnt + CNT_W'(do_push) - CNT_W'(do_pop);
		end
	end

	if (DEPTH < 2) begin : g_chk
		$error("sseq_errq: DEPTH must be at least 2");
	end
endmodule // sseq_errq

// >>> core/sseq_top.sv
// status registers, enable entry, message filter and error queue reads
`timescale 1ns/100ps
module sseq_top #(
	parameter int Q_DEPTH = sseq_pkg::Q_DEPTH,
	parameter int LIST_N  = sseq_pkg::LIST_N
) (
	// clock and reset (reset is power-up)
	input  wire logic                                      clk_i,
	input  wire logic                                      srst_i,
	// decoded commands, one-cycle pulses
	input  wire logic                                      cls_i,
	input  wire logic                                      stat_preset_i,
	input  wire logic                                      rst_cmd_i,
	input  wire logic                                      sys_preset_i,
	input  wire logic                                      q_clear_i,
	// instrument conditions and group summaries
	input  wire logic [sseq_pkg::GRP_N*sseq_pkg::REG_W-1:0] cond_i,
	output logic      [sseq_pkg::GRP_N-1:0]                 summary_o,
	// register queries
	input  wire logic                                      reg_rd_i,
	input  wire logic [1:0]                                reg_grp_i,
	input  wire logic [1:0]                                reg_sel_i,
	input  wire logic [1:0]                                fmt_sel_i,
	output logic                                           rd_valid_o,
	output logic      [sseq_pkg::REG_W-1:0]                 rd_data_o,
	output logic      [1:0]                                rd_fmt_o,
	// enable register entry, one digit per cycle
	input  wire logic                                      en_start_i,
	input  wire logic [1:0]                                en_grp_i,
	input  wire logic [1:0]                                en_radix_i,
	input  wire logic                                      en_dig_valid_i,
	input  wire logic [3:0]                                en_dig_i,
	input  wire logic                                      en_commit_i,
	output logic                                           en_bad_o,
	// messages raised by the instrument
	input  wire logic                                      err_valid_i,
	input  wire logic [sseq_pkg::CODE_W-1:0]                err_code_i,
	input  wire logic [sseq_pkg::MSG_W-1:0]                 err_msg_i,
	// enable and disable message lists
	input  wire logic                                      list_wr_i,
	input  wire logic                                      list_rd_i,
	input  wire logic                                      list_sel_i,
	input  wire logic [$clog2(LIST_N)-1:0]                 list_idx_i,
	input  wire logic                                      list_on_i,
	input  wire logic [sseq_pkg::CODE_W-1:0]                list_code_i,
	output logic                                           list_valid_o,
	output logic                                           list_on_o,
	output logic      [sseq_pkg::CODE_W-1:0]                list_code_o,
	// error queue reads
	input  wire logic                                      q_next_i,
	input  wire logic                                      q_all_i,
	input  wire logic                                      q_count_i,
	input  wire logic                                      q_code_only_i,
	output logic                                           rsp_valid_o,
	output logic      [sseq_pkg::CODE_W-1:0]                rsp_code_o,
	output logic      [sseq_pkg::MSG_W-1:0]                 rsp_msg_o,
	output logic                                           rsp_has_msg_o,
	output logic                                           rsp_last_o,
	output logic                                           q_busy_o,
	output logic                                           cnt_valid_o,
	output logic      [$clog2(Q_DEPTH+1)-1:0]              cnt_o
);
	localparam int W = sseq_pkg::REG_W;
	localparam int CW = sseq_pkg::CODE_W;
	localparam int LW = $clog2(LIST_N);
	localparam int CNT_W = $clog2(Q_DEPTH + 1);

	typedef enum logic [1:0] {
		SSEQ_IDLE  = 2'b01,
		SSEQ_DRAIN = 2'b10
	} sseq_state_type;

	// rst_cmd_i and sys_preset_i are deliberately read by nothing here
	logic [W-1:0]  cond_q  [sseq_pkg::GRP_N];
	logic [W-1:0]  event_r [sseq_pkg::GRP_N];
	logic [W-1:0]  enab_r  [sseq_pkg::GRP_N];
	logic [W-1:0]  acc;
	logic          acc_bad;
	logic [1:0]    acc_radix;
	logic [1:0]    acc_grp;
	logic [CW-1:0] list_code [2][LIST_N];
	logic          list_on   [2][LIST_N];
	logic          drain_code_only;
	sseq_state_type state;
	sseq_state_type next_state;

	sseq_q_if #(.DEPTH(Q_DEPTH), .CODE_W(CW), .MSG_W(sseq_pkg::MSG_W)) qi ();

	sseq_errq #(.DEPTH(Q_DEPTH), .CODE_W(CW), .MSG_W(sseq_pkg::MSG_W)) u_errq (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.q      (qi.queue)
	);

	// list lookup for the queue filter
	function automatic logic in_list(input logic [CW-1:0] c, input logic [CW-1:0] codes [LIST_N],
			input logic ons [LIST_N]);
		in_list = 1'b0;
		for (int i = 0; i < LIST_N; i++) begin
			if (ons[i] && codes[i] == c) in_list = 1'b1;
		end
	endfunction

	// a digit is legal only below its radix
	function automatic logic dig_ok(input logic [1:0] r, input logic [3:0] d);
		case (r)
			sseq_pkg::RADIX_DEC: dig_ok = d < 4'ha;
			sseq_pkg::RADIX_OCT: dig_ok = d < 4'h8;
			sseq_pkg::RADIX_BIN: dig_ok = d < 4'h2;
			default:             dig_ok = 1'b1;
		endcase
	endfunction

	// status groups: rising condition sets, a set in the clearing cycle survives
	for (genvar g = 0; g < sseq_pkg::GRP_N; g++) begin : g_grp
		wire [W-1:0] cond_now = cond_i[g*W +: W];
		wire [W-1:0] ev_set   = cond_now & ~cond_q[g];
		wire         wr_en    = en_commit_i & ~acc_bad & (acc_grp == 2'(g));

		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				cond_q[g]  <= '0;
				event_r[g] <= sseq_pkg::EVENT_RST;
				enab_r[g]  <= sseq_pkg::ENABLE_RST;
				summary_o[g] <= 1'b0;
			end else begin
				cond_q[g]  <= cond_now;
				event_r[g] <= (cls_i ? '0 : event_r[g]) | ev_set;
				if (wr_en) enab_r[g] <= acc;
				else if (stat_preset_i) enab_r[g] <= '0;
				summary_o[g] <= |(event_r[g] & enab_r[g]);
			end
		end
	end

	// register query selection; group 3 and select 3 read as zero
	wire          grp_ok  = reg_grp_i <= sseq_pkg::GRP_QUES;
	wire [1:0]    grp_ix  = grp_ok ? reg_grp_i : 2'h0;
	wire [W-1:0]  rd_pick = (reg_sel_i == sseq_pkg::SEL_COND)   ? cond_q[grp_ix] :
	                        (reg_sel_i == sseq_pkg::SEL_EVENT)  ? event_r[grp_ix] :
	                        (reg_sel_i == sseq_pkg::SEL_ENABLE) ? enab_r[grp_ix] : '0;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
			rd_fmt_o   <= sseq_pkg::RADIX_DEC;
		end else begin
			rd_valid_o <= reg_rd_i;
			if (reg_rd_i) begin
				rd_data_o <= grp_ok ? rd_pick : '0;
				rd_fmt_o  <= fmt_sel_i;
			end
		end
	end

	// number entry: the radix shift replaces a multiplier; values wider than W wrap
	wire [1:0]   use_rad  = en_start_i ? en_radix_i : acc_radix;
	wire [W-1:0] acc_in   = en_start_i ? '0 : acc;
	wire [W-1:0] dig_w    = W'(en_dig_i);
	wire [W-1:0] next_acc = (use_rad == sseq_pkg::RADIX_DEC) ? (acc_in << 3) + (acc_in << 1) + dig_w :
	                        (use_rad == sseq_pkg::RADIX_HEX) ? (acc_in << 4) | dig_w :
	                        (use_rad == sseq_pkg::RADIX_OCT) ? (acc_in << 3) | dig_w : (acc_in << 1) | dig_w;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc       <= '0;
			acc_bad   <= 1'b0;
			acc_radix <= sseq_pkg::RADIX_DEC;
			acc_grp   <= sseq_pkg::GRP_MEAS;
			en_bad_o  <= 1'b0;
		end else begin
			en_bad_o <= en_commit_i & (acc_bad | acc_grp > sseq_pkg::GRP_QUES);
			if (en_start_i) begin
				acc_radix <= en_radix_i;
				acc_grp   <= en_grp_i;
				acc       <= '0;
				acc_bad   <= 1'b0;
			end
			if (en_dig_valid_i) begin
				acc <= next_acc;
				if (!dig_ok(use_rad, en_dig_i)) acc_bad <= 1'b1;
			end
		end
	end

	// message lists: writing a code into the enable list lifts it from the disable list
	wire on_dis = in_list(err_code_i, list_code[sseq_pkg::LIST_DISABLE], list_on[sseq_pkg::LIST_DISABLE]);

	for (genvar l = 0; l < 2; l++) begin : g_list
		for (genvar s = 0; s < LIST_N; s++) begin : g_slot
			wire wr_me  = list_wr_i & (list_sel_i == 1'(l)) & (list_idx_i == LW'(s));
			wire hit_en = (1'(l) == sseq_pkg::LIST_DISABLE) & list_wr_i & list_on_i
			              & (list_sel_i == sseq_pkg::LIST_ENABLE) & list_on[l][s] & (list_code[l][s] == list_code_i);

			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					list_on[l][s]   <= 1'b0;
					list_code[l][s] <= '0;
				end else if (wr_me) begin
					list_on[l][s]   <= list_on_i;
					list_code[l][s] <= list_code_i;
				end else if (hit_en) begin
					list_on[l][s] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			list_valid_o <= 1'b0;
			list_on_o    <= 1'b0;
			list_code_o  <= '0;
		end else begin
			list_valid_o <= list_rd_i;
			if (list_rd_i) begin
				list_on_o   <= list_on[list_sel_i][list_idx_i];
				list_code_o <= list_code[list_sel_i][list_idx_i];
			end
		end
	end

	// queue control; the preset and reset commands never reach clr
	wire q_empty = qi.count == '0;
	wire idle    = state == SSEQ_IDLE;
	wire do_next = idle & q_next_i;
	wire start_all = idle & ~q_next_i & q_all_i;
	wire q_clr   = cls_i | q_clear_i;
	wire drain_pop = (state == SSEQ_DRAIN) & ~q_empty;
	wire tail_now  = q_empty | (qi.count == CNT_W'(1) & ~qi.push);
	wire drain_end = (state == SSEQ_DRAIN) & tail_now;

	assign qi.push      = err_valid_i & ~on_dis;
	assign qi.push_code = err_code_i;
	assign qi.push_msg  = err_msg_i;
	assign qi.pop       = (do_next | start_all | drain_pop) & ~q_clr;
	assign qi.clr       = q_clr;
	assign q_busy_o     = ~idle;

	always_comb begin
		next_state = state;
		case (state)
			SSEQ_IDLE:  if (start_all && !tail_now && !q_clr) next_state = SSEQ_DRAIN;
			SSEQ_DRAIN: if (drain_end || q_clr) next_state = SSEQ_IDLE;
			default:    next_state = SSEQ_IDLE;
		endcase
	end

	// answers: an empty queue answers with the no-error entry
	wire emit    = ((do_next | start_all) & ~q_clr) | (drain_pop & ~q_clr);
	wire code_on = start_all | do_next ? q_code_only_i : drain_code_only;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state           <= SSEQ_IDLE;
			drain_code_only <= 1'b0;
			rsp_valid_o     <= 1'b0;
			rsp_code_o      <= '0;
			rsp_msg_o       <= '0;
			rsp_has_msg_o   <= 1'b0;
			rsp_last_o      <= 1'b0;
			cnt_valid_o     <= 1'b0;
			cnt_o           <= '0;
		end else begin
			state       <= next_state;
			rsp_valid_o <= emit;
			cnt_valid_o <= q_count_i;
			if (q_count_i) cnt_o <= qi.count;
			if (start_all) drain_code_only <= q_code_only_i;
			if (emit) begin
				rsp_code_o    <= q_empty ? sseq_pkg::NO_ERR_CODE : qi.head_code;
				rsp_msg_o     <= (q_empty || code_on) ? sseq_pkg::NO_ERR_MSG : qi.head_msg;
				rsp_has_msg_o <= ~code_on;
				rsp_last_o    <= do_next | (start_all & tail_now) | drain_end;
			end
		end
	end

	if (Q_DEPTH < 2 || LIST_N < 2) begin : g_chk
		$error("sseq_top: Q_DEPTH and LIST_N must be at least 2");
	end
endmodule // sseq_top

// >>> tb/sseq_checker.sv
// port assertions for the status event and error queue block
`timescale 1ns/100ps
module sseq_checker #(
	parameter int Q_DEPTH = sseq_pkg::Q_DEPTH,
	parameter int LIST_N  = sseq_pkg::LIST_N
) (
	// clock and reset
	input wire logic                       clk_i,
	input wire logic                       srst_i,
	// register queries
	input wire logic                       reg_rd_i,
	input wire logic [1:0]                 reg_grp_i,
	input wire logic [1:0]                 fmt_sel_i,
	input wire logic                       rd_valid_o,
	input wire logic [sseq_pkg::REG_W-1:0] rd_data_o,
	input wire logic [1:0]                 rd_fmt_o,
	// error queue reads
	input wire logic                       q_next_i,
	input wire logic                       q_all_i,
	input wire logic                       q_count_i,
	input wire logic                       q_code_only_i,
	input wire logic                       q_busy_o,
	input wire logic                       rsp_valid_o,
	input wire logic [sseq_pkg::MSG_W-1:0] rsp_msg_o,
	input wire logic                       rsp_has_msg_o,
	input wire logic                       rsp_last_o,
	input wire logic                       cnt_valid_o
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_rd_lat; reg_rd_i |=> rd_valid_o; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("query answer missing");
	property p_rd_quiet; !reg_rd_i |=> !rd_valid_o; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("answer without query");
	property p_rd_fmt; reg_rd_i |=> rd_fmt_o == $past(fmt_sel_i); endproperty
	a_rd_fmt: assert property (p_rd_fmt) else $error("answer format differs");
	property p_rd_grp3; reg_rd_i && reg_grp_i == 2'h3 |=> rd_data_o == 16'h0000; endproperty
	a_rd_grp3: assert property (p_rd_grp3) else $error("unused group not zero");
	property p_cnt; q_count_i |=> cnt_valid_o; endproperty
	a_cnt: assert property (p_cnt) else $error("count answer missing");
	property p_cnt_quiet; !q_count_i |=> !cnt_valid_o; endproperty
	a_cnt_quiet: assert property (p_cnt_quiet) else $error("count without request");
	property p_next; q_next_i && !q_busy_o |=> rsp_valid_o && rsp_last_o; endproperty
	a_next: assert property (p_next) else $error("next read answer wrong");
	property p_all; q_all_i && !q_busy_o |=> rsp_valid_o; endproperty
	a_all: assert property (p_all) else $error("all read did not start");
	property p_code_only;
		(q_next_i || q_all_i) && !q_busy_o && q_code_only_i |=> !rsp_has_msg_o && rsp_msg_o == 8'h00;
	endproperty
	a_code_only: assert property (p_code_only) else $error("code read carried text");
	// main scenarios reached
	c_all: cover property (q_all_i && !q_busy_o);
	c_code: cover property (rsp_valid_o && !rsp_has_msg_o);
	c_bin: cover property (rd_valid_o && rd_fmt_o == 2'h3);
endmodule // sseq_checker

bind sseq_top sseq_checker #(.Q_DEPTH(Q_DEPTH), .LIST_N(LIST_N)) u_sseq_checker (
	.clk_i(clk_i), .srst_i(srst_i), .reg_rd_i(reg_rd_i), .reg_grp_i(reg_grp_i), .fmt_sel_i(fmt_sel_i),
	.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_fmt_o(rd_fmt_o), .q_next_i(q_next_i),
	.q_all_i(q_all_i), .q_count_i(q_count_i), .q_code_only_i(q_code_only_i), .q_busy_o(q_busy_o),
	.rsp_valid_o(rsp_valid_o), .rsp_msg_o(rsp_msg_o), .rsp_has_msg_o(rsp_has_msg_o),
	.rsp_last_o(rsp_last_o), .cnt_valid_o(cnt_valid_o));

// >>> tb/sseq_host_model.sv
// host model: raises messages and issues error queue reads
`timescale 1ns/100ps
module sseq_host_model (
	// clock and drain flag
	input  wire logic clk_i,
	input  wire logic busy_i,
	// message and read requests
	output logic        err_valid_o,
	output logic [15:0] err_code_o,
	output logic [7:0]  err_msg_o,
	output logic [1:0]  kind_o,
	output logic        code_only_o
);
	// nothing requested at time zero
	initial {err_valid_o, err_code_o, err_msg_o, kind_o, code_only_o} = {25'h0, 2'h3, 1'b0};
	// released data shows the inverse so a stale value never looks valid
	task automatic raise(input logic [15:0] c, input logic [7:0] m);
		@(posedge clk_i);
		#1;
		err_valid_o = 1'b1;
		err_code_o = c;
		err_msg_o = m;
		@(posedge clk_i);
		#1;
		err_valid_o = 1'b0;
		err_code_o = ~c;
		err_msg_o = ~m;
	endtask
	// read request (0 next, 1 all, 2 count) only once no drain runs
	task automatic ask(input logic [1:0] k, input logic co);
		int i = 0;
		@(posedge clk_i);
		#1;
		while (busy_i !== 1'b0 && i < 64) begin
			@(posedge clk_i);
			#1;
			i++;
		end
		kind_o = k;
		code_only_o = co;
		@(posedge clk_i);
		#1;
		kind_o = 2'h3;
		code_only_o = ~co;
	endtask
endmodule // sseq_host_model

// >>> tb/test_status_event_error_queue.sv
// self-checking bench for the status event and error queue block
`timescale 1ns/100ps
module test_status_event_error_queue;
	logic clk_i, srst_i, reg_rd_i, en_start_i, en_dig_valid_i, en_commit_i, en_bad_o;
	logic list_wr_i, list_rd_i, list_sel_i, list_on_i, list_valid_o, list_on_o, err_valid_i, q_code_only_i;
	logic rd_valid_o, rsp_valid_o, rsp_has_msg_o, rsp_last_o, q_busy_o, cnt_valid_o;
	logic [4:0] cmdv;
	logic [1:0] reg_grp_i, reg_sel_i, fmt_sel_i, rd_fmt_o, en_grp_i, en_radix_i, q_kind;
	logic [2:0] summary_o, list_idx_i;
	logic [3:0] en_dig_i, cnt_o;
	logic [7:0] err_msg_i, rsp_msg_o;
	logic [15:0] rd_data_o, err_code_i, list_code_i, list_code_o, rsp_code_o;
	logic [47:0] cond_i;
	logic [15:0] en_m [3];
	logic [23:0] mq [$];
	logic [17:0] exp_rd [$];
	logic [25:0] exp_rsp [$];
	logic [3:0] exp_cnt [$];
	int n_mismatch = 0;
	int total_checks = 0;

	sseq_top u_sseq_top (.clk_i(clk_i), .srst_i(srst_i), .cls_i(cmdv[0]), .stat_preset_i(cmdv[1]),
		.rst_cmd_i(cmdv[2]), .sys_preset_i(cmdv[3]), .q_clear_i(cmdv[4]), .cond_i(cond_i), .summary_o(summary_o),
		.reg_rd_i(reg_rd_i), .reg_grp_i(reg_grp_i), .reg_sel_i(reg_sel_i), .fmt_sel_i(fmt_sel_i),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_fmt_o(rd_fmt_o), .en_start_i(en_start_i),
		.en_grp_i(en_grp_i), .en_radix_i(en_radix_i), .en_dig_valid_i(en_dig_valid_i), .en_dig_i(en_dig_i),
		.en_commit_i(en_commit_i), .en_bad_o(en_bad_o), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
		.err_msg_i(err_msg_i), .list_wr_i(list_wr_i), .list_rd_i(list_rd_i), .list_sel_i(list_sel_i),
		.list_idx_i(list_idx_i), .list_on_i(list_on_i), .list_code_i(list_code_i), .list_valid_o(list_valid_o),
		.list_on_o(list_on_o), .list_code_o(list_code_o), .q_next_i(q_kind == 2'h0), .q_all_i(q_kind == 2'h1),
		.q_count_i(q_kind == 2'h2), .q_code_only_i(q_code_only_i), .rsp_valid_o(rsp_valid_o),
		.rsp_code_o(rsp_code_o), .rsp_msg_o(rsp_msg_o), .rsp_has_msg_o(rsp_has_msg_o), .rsp_last_o(rsp_last_o),
		.q_busy_o(q_busy_o), .cnt_valid_o(cnt_valid_o), .cnt_o(cnt_o));
	sseq_host_model u_sseq_host_model (.clk_i(clk_i), .busy_i(q_busy_o), .err_valid_o(err_valid_i),
		.err_code_o(err_code_i), .err_msg_o(err_msg_i), .kind_o(q_kind), .code_only_o(q_code_only_i));

	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one-cycle command pulse: bit 0 clear-status, 1 status preset, 2 reset, 3 system preset, 4 queue clear
	task automatic cmd(input logic [4:0] v);
		@(posedge clk_i);
		#1;
		cmdv = v;
		@(posedge clk_i);
		#1;
		cmdv = 5'h00;
	endtask
	// register query, random answer format
	task automatic rd(input logic [1:0] g, input logic [1:0] s, input logic [15:0] e);
		fmt_sel_i = 2'($urandom);
		exp_rd.push_back({e, fmt_sel_i});
		@(posedge clk_i);
		#1;
		reg_rd_i = 1'b1;
		reg_grp_i = g;
		reg_sel_i = s;
		@(posedge clk_i);
		#1;
		reg_rd_i = 1'b0;
	endtask
	// enable entry, digits MSB first; a bad entry starts with an illegal digit
	task automatic entry(input logic [1:0] g, input logic [1:0] r, input logic [15:0] v, input bit bad);
		logic [3:0] d [17];
		int n, b, x;
		b = (r == sseq_pkg::RADIX_DEC) ? 10 : (r == sseq_pkg::RADIX_HEX) ? 16 : (r == sseq_pkg::RADIX_OCT) ? 8 : 2;
		x = v;
		n = 0;
		do begin
			d[n] = 4'(x % b);
			x = x / b;
			n++;
		end while (x > 0);
		if (bad) d[n++] = 4'hf;
		@(posedge clk_i);
		#1;
		en_start_i = 1'b1;
		en_grp_i = g;
		en_radix_i = r;
		@(posedge clk_i);
		#1;
		en_start_i = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			en_dig_valid_i = 1'b1;
			en_dig_i = d[i];
			@(posedge clk_i);
			#1;
		end
		en_dig_valid_i = 1'b0;
		en_commit_i = 1'b1;
		@(posedge clk_i);
		#1;
		en_commit_i = 1'b0;
		chk("en_bad", en_bad_o, bad);
		if (!bad) en_m[g] = v;
		rd(g, sseq_pkg::SEL_ENABLE, en_m[g]);
	endtask
	// list slot write, or read that is checked on its answer cycle
	task automatic lst(input bit wr, input logic s, input logic [2:0] i, input logic on, input logic [15:0] c);
		@(posedge clk_i);
		#1;
		{list_wr_i, list_rd_i, list_sel_i, list_idx_i, list_on_i, list_code_i} = {wr, !wr, s, i, on, c};
		@(posedge clk_i);
		#1;
		{list_wr_i, list_rd_i} = 2'h0;
		if (!wr) chk("list", {list_valid_o, list_on_o, list_code_o}, {2'h3, c});
	endtask
	task automatic raise(input logic [15:0] c, input bit q);
		logic [7:0] m;
		m = 8'($urandom);
		if (q) mq.push_back({c, m});
		u_sseq_host_model.raise(c, m);
	endtask
	// queue read: expectations taken off the bench's copy of the queue
	task automatic qread(input logic [1:0] k, input logic co);
		logic [23:0] e;
		if (k == 2'h2) begin
			exp_cnt.push_back(4'(mq.size()));
		end else begin
			do begin
				e = mq.pop_front();
				exp_rsp.push_back({e[23:8], co ? 8'h00 : e[7:0], !co, k == 2'h0 || mq.size() == 0});
			end while (k == 2'h1 && mq.size() > 0);
		end
		u_sseq_host_model.ask(k, co);
	endtask
	// answers are matched against the oldest note
	always @(negedge clk_i) begin
		if (rd_valid_o === 1'b1) chk("rd", {rd_data_o, rd_fmt_o}, exp_rd.size() ? exp_rd.pop_front() : 'x);
		if (rsp_valid_o === 1'b1) chk("rsp", {rsp_code_o, rsp_msg_o, rsp_has_msg_o, rsp_last_o},
			exp_rsp.size() ? exp_rsp.pop_front() : 'x);
		if (cnt_valid_o === 1'b1) chk("cnt", cnt_o, exp_cnt.size() ? exp_cnt.pop_front() : 'x);
	end
	// watchdog well past a run of a few hundred cycles
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end
	initial begin
		{reg_rd_i, en_start_i, en_dig_valid_i, en_commit_i, list_wr_i, list_rd_i, list_sel_i, list_on_i} = 8'h00;
		{cmdv, reg_grp_i, reg_sel_i, fmt_sel_i, en_grp_i, en_radix_i, list_idx_i, en_dig_i} = 24'h000000;
		{cond_i, list_code_i} = 64'h0;
		en_m = '{default: 16'h0000};
		void'($urandom(32'h21d4));
		srst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		for (int g = 0; g < 3; g++) begin
			rd(2'(g), sseq_pkg::SEL_EVENT, 16'h0000);
			rd(2'(g), sseq_pkg::SEL_COND, 16'h0000);
		end
		for (int r = 0; r < 4; r++) entry(2'(r % 3), 2'(r), 16'($urandom), 1'b0);
		entry(2'h2, sseq_pkg::RADIX_DEC, 16'h0007, 1'b1);
		rd(2'h3, sseq_pkg::SEL_ENABLE, 16'h0000);
		// events in the operation group
		entry(2'h1, sseq_pkg::RADIX_HEX, 16'h0005, 1'b0);
		cond_i[16] = 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk("sum", summary_o[1], 1'b1);
		cond_i[16] = 1'b0;
		cmd(5'h0c);
		rd(2'h1, sseq_pkg::SEL_EVENT, 16'h0001);
		rd(2'h1, sseq_pkg::SEL_ENABLE, 16'h0005);
		cmd(5'h01);
		rd(2'h1, sseq_pkg::SEL_EVENT, 16'h0000);
		rd(2'h1, sseq_pkg::SEL_ENABLE, 16'h0005);
		cond_i[18] = 1'b1;
		repeat (3) @(posedge clk_i);
		cmd(5'h02);
		rd(2'h1, sseq_pkg::SEL_EVENT, 16'h0004);
		rd(2'h1, sseq_pkg::SEL_ENABLE, 16'h0000);
		rd(2'h1, sseq_pkg::SEL_COND, 16'h0004);
		chk("sum", summary_o[1], 1'b0);
		// error queue
		repeat (3) raise(16'h8000 | 16'($urandom), 1'b1);
		qread(2'h2, 1'b0);
		qread(2'h2, 1'b0);
		qread(2'h0, 1'b0);
		qread(2'h0, 1'b1);
		cmd(5'h0e);
		qread(2'h2, 1'b0);
		repeat (2) raise(16'h8000 | 16'($urandom), 1'b1);
		qread(2'h1, 1'b0);
		qread(2'h2, 1'b0);
		repeat (2) raise(16'h4000 | 16'($urandom), 1'b1);
		qread(2'h1, 1'b1);
		repeat (2) raise(16'h8000 | 16'($urandom), 1'b1);
		cmd(5'h10);
		mq.delete();
		qread(2'h2, 1'b0);
		raise(16'h8001, 1'b1);
		cmd(5'h01);
		mq.delete();
		qread(2'h2, 1'b0);
		// message lists
		lst(1'b1, sseq_pkg::LIST_DISABLE, 3'h0, 1'b1, 16'h0123);
		lst(1'b1, sseq_pkg::LIST_ENABLE, 3'h1, 1'b1, 16'h0456);
		raise(16'h0123, 1'b0);
		raise(16'h0124, 1'b1);
		qread(2'h2, 1'b0);
		cmd(5'h03);
		mq.delete();
		lst(1'b0, sseq_pkg::LIST_DISABLE, 3'h0, 1'b1, 16'h0123);
		lst(1'b0, sseq_pkg::LIST_ENABLE, 3'h1, 1'b1, 16'h0456);
		repeat (20) @(posedge clk_i);
		chk("left", exp_rd.size() + exp_rsp.size() + exp_cnt.size(), 0);
		close_out();
	end
endmodule // test_status_event_error_queue
